// *** rtl/txsc_pkg.sv ***
// Package: offsets, field layout, reset values and counts of the transmitter config bank
package txsc_pkg;
  // Register offsets on the serial register port
  localparam logic [5:0] OFF_MAIN_SM_CFG = 6'h18;
  localparam logic [5:0] OFF_FRONT_END   = 6'h22;
  localparam logic [5:0] OFF_SYNTH_CAL_A = 6'h23;

  // Field positions
  localparam int TIMEOUT_LSB   = 2;
  localparam int LEVEL_LSB     = 0;
  localparam int LOBUF_LSB     = 4;
  localparam int CALRES_LSB    = 0;
  localparam int CALSTAGE_LSB  = 4;
  localparam int CALCFG_LSB    = 6;

  // Reset values
  localparam logic [1:0] RST_TIMEOUT  = 2'h2;
  localparam logic [2:0] RST_LEVEL    = 3'h0;
  localparam logic [1:0] RST_LOBUF    = 2'h1;
  localparam logic [1:0] RST_CALCFG   = 2'h2;
  localparam logic [1:0] RST_CALSTAGE = 2'h2;
  localparam logic [3:0] RST_CALRES   = 4'h9;

  // Ripple-counter expiry counts per timeout code
  localparam logic [8:0] EXPIRE_CODE0 = 9'h001;
  localparam logic [8:0] EXPIRE_CODE1 = 9'h010;
  localparam logic [8:0] EXPIRE_CODE2 = 9'h040;
  localparam logic [8:0] EXPIRE_CODE3 = 9'h100;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } txsc_req_s;

  // Calibration result update from the synthesizer
  typedef struct packed {
    logic       valid;
    logic [3:0] value;
  } txsc_cal_s;

  // Startup sequencer states
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_COUNT = 2'b01,
    ST_READY = 2'b10
  } txsc_state_e;
endpackage

// *** rtl/txsc_wake_timer.sv ***
// Wake-up timer: counts ripple-counter expiries after crystal start
`timescale 1ns/100ps
module txsc_wake_timer #(
  parameter int CNT_W = 9
) (
  input  wire logic                 MCLK,
  input  wire logic                 RST_N,
  input  wire logic                 XOSC_STABLE,
  input  wire logic                 RIPPLE_EXPIRE,
  input  wire logic [1:0]           TIMEOUT_SEL,
  output logic                      CHIP_READY_N
);
  typedef struct packed {
    txsc_pkg::txsc_state_e state;
    logic [CNT_W-1:0]      cnt;
    logic                  ready_n;
  } txsc_tmr_s;

  txsc_tmr_s st_ff;
  txsc_tmr_s nxt_st;

  // Expiry count decode
  function automatic logic [CNT_W-1:0] expire_count(input logic [1:0] sel);
    case (sel)
      2'h0:    expire_count = CNT_W'(txsc_pkg::EXPIRE_CODE0);
      2'h1:    expire_count = CNT_W'(txsc_pkg::EXPIRE_CODE1);
      2'h2:    expire_count = CNT_W'(txsc_pkg::EXPIRE_CODE2);
      default: expire_count = CNT_W'(txsc_pkg::EXPIRE_CODE3);
    endcase
  endfunction

  // Sequencer; losing the crystal restarts the wait
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.state)
      txsc_pkg::ST_OFF: begin
        nxt_st.cnt     = '0;
        nxt_st.ready_n = 1'b1;
        if (XOSC_STABLE) begin
          nxt_st.state = txsc_pkg::ST_COUNT;
        end
      end
      txsc_pkg::ST_COUNT: begin
        if (!XOSC_STABLE) begin
          nxt_st.state = txsc_pkg::ST_OFF;
        end else if (RIPPLE_EXPIRE) begin
          nxt_st.cnt = st_ff.cnt + CNT_W'(1);
          if (st_ff.cnt + CNT_W'(1) >= expire_count(TIMEOUT_SEL)) begin
            nxt_st.state   = txsc_pkg::ST_READY;
            nxt_st.ready_n = 1'b0;
          end
        end
      end
      txsc_pkg::ST_READY: begin
        if (!XOSC_STABLE) begin
          nxt_st.state   = txsc_pkg::ST_OFF;
          nxt_st.ready_n = 1'b1;
        end
      end
      default: nxt_st.state = txsc_pkg::ST_OFF;
    endcase
  end

  // State register
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_ff <= '{state: txsc_pkg::ST_OFF, cnt: '0, ready_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign CHIP_READY_N = st_ff.ready_n;
endmodule

// *** rtl/txsc_top.sv ***
// Top: transmitter startup timeout and synthesizer/front-end configuration bank
`timescale 1ns/100ps
// Function
// - Timeout code selects 1, 16, 64, 256 expiries
// - Timeout select survives sleep
// - Level index bits 2:0, reset 0
// - OOK one symbol uses indexed table entry
// - OOK zero symbol uses table entry zero
// - LO buffer current bits 5:4, reset 01
// - Pump cal stage enable zero skips stage
// - Cal result bits 3:0, reset 9, writable
// - Timeout bits 3:2, reset 2, gates ready
module txsc_top (
  input  wire logic                   MCLK,
  input  wire logic                   RST_N,
  input  wire logic                   SLEEP,
  input  wire txsc_pkg::txsc_req_s    REG_REQ,
  output logic [7:0]                  REG_RDATA,
  input  wire txsc_pkg::txsc_cal_s    CAL_RESULT,
  input  wire logic                   OOK_MODE,
  input  wire logic                   TX_SYMBOL,
  output logic [2:0]                  TABLE_SEL,
  output logic [1:0]                  LO_BUFFER_CURRENT,
  output logic [1:0]                  CAL_CONFIG,
  output logic                        PUMP_CAL_STAGE_EN,
  output logic [3:0]                  PUMP_CURRENT,
  input  wire logic                   XOSC_STABLE,
  input  wire logic                   RIPPLE_EXPIRE,
  output logic                        CHIP_READY_N
);
  typedef struct packed {
    logic [1:0] timeout_sel;
    logic [2:0] level_idx;
    logic [1:0] lo_buf;
    logic [1:0] cal_cfg;
    logic [1:0] cal_stage;
    logic [3:0] cal_res;
    logic [2:0] table_sel;
    logic [7:0] rdata;
  } txsc_regs_s;

  txsc_regs_s st_ff;
  txsc_regs_s nxt_st;

  // Read-back assembly; reserved positions stay zero
  function automatic logic [7:0] read_word(input txsc_regs_s s, input logic [5:0] a);
    logic [7:0] w;
    w = 8'h00;
    case (a)
      txsc_pkg::OFF_MAIN_SM_CFG: w[txsc_pkg::TIMEOUT_LSB +: 2] = s.timeout_sel;
      txsc_pkg::OFF_FRONT_END: begin
        w[txsc_pkg::LOBUF_LSB +: 2] = s.lo_buf;
        w[txsc_pkg::LEVEL_LSB +: 3] = s.level_idx;
      end
      txsc_pkg::OFF_SYNTH_CAL_A: begin
        w[txsc_pkg::CALCFG_LSB +: 2]   = s.cal_cfg;
        w[txsc_pkg::CALSTAGE_LSB +: 2] = s.cal_stage;
        w[txsc_pkg::CALRES_LSB +: 4]   = s.cal_res;
      end
      default: w = 8'h00;
    endcase
    read_word = w;
  endfunction

  // Register writes, result capture and table index choice
  always_comb begin
    nxt_st = st_ff;
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        txsc_pkg::OFF_MAIN_SM_CFG: nxt_st.timeout_sel = REG_REQ.wdata[txsc_pkg::TIMEOUT_LSB +: 2];
        txsc_pkg::OFF_FRONT_END: begin
          nxt_st.level_idx = REG_REQ.wdata[txsc_pkg::LEVEL_LSB +: 3];
          nxt_st.lo_buf    = REG_REQ.wdata[txsc_pkg::LOBUF_LSB +: 2];
        end
        txsc_pkg::OFF_SYNTH_CAL_A: begin
          nxt_st.cal_cfg   = REG_REQ.wdata[txsc_pkg::CALCFG_LSB +: 2];
          nxt_st.cal_stage = REG_REQ.wdata[txsc_pkg::CALSTAGE_LSB +: 2];
          nxt_st.cal_res   = REG_REQ.wdata[txsc_pkg::CALRES_LSB +: 4];
        end
        default: nxt_st.cal_res = st_ff.cal_res;
      endcase
    end
    // Calibration engine result wins over a same-cycle host override
    if (CAL_RESULT.valid) begin
      nxt_st.cal_res = CAL_RESULT.value;
    end
    // OOK zero forces entry zero; otherwise the programmed index
    if (OOK_MODE && !TX_SYMBOL) begin
      nxt_st.table_sel = 3'h0;
    end else begin
      nxt_st.table_sel = st_ff.level_idx;
    end
    nxt_st.rdata = REG_REQ.rd ? read_word(st_ff, REG_REQ.addr) : st_ff.rdata;
    // Sleep wipes the config fields except the timeout select; table index and read data are not reset
    if (SLEEP) begin
      nxt_st.level_idx = txsc_pkg::RST_LEVEL;
      nxt_st.lo_buf    = txsc_pkg::RST_LOBUF;
      nxt_st.cal_cfg   = txsc_pkg::RST_CALCFG;
      nxt_st.cal_stage = txsc_pkg::RST_CALSTAGE;
      nxt_st.cal_res   = txsc_pkg::RST_CALRES;
    end
  end

  // Bank register; only reset, never sleep, restores the timeout select
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_ff.timeout_sel <= txsc_pkg::RST_TIMEOUT;
      st_ff.level_idx   <= txsc_pkg::RST_LEVEL;
      st_ff.lo_buf      <= txsc_pkg::RST_LOBUF;
      st_ff.cal_cfg     <= txsc_pkg::RST_CALCFG;
      st_ff.cal_stage   <= txsc_pkg::RST_CALSTAGE;
      st_ff.cal_res     <= txsc_pkg::RST_CALRES;
      st_ff.table_sel   <= 3'h0;
      st_ff.rdata       <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Wake-up timer driven by the retained select
  txsc_wake_timer #(
    .CNT_W (9)
  ) u_wake (
    .MCLK          (MCLK),
    .RST_N         (RST_N),
    .XOSC_STABLE   (XOSC_STABLE),
    .RIPPLE_EXPIRE (RIPPLE_EXPIRE),
    .TIMEOUT_SEL   (st_ff.timeout_sel),
    .CHIP_READY_N  (CHIP_READY_N)
  );

  assign REG_RDATA         = st_ff.rdata;
  assign TABLE_SEL         = st_ff.table_sel;
  assign LO_BUFFER_CURRENT = st_ff.lo_buf;
  assign CAL_CONFIG        = st_ff.cal_cfg;
  assign PUMP_CAL_STAGE_EN = |st_ff.cal_stage;
  assign PUMP_CURRENT      = st_ff.cal_res;
endmodule

// *** dv/txsc_monitor.sv ***
// Checker: port-level properties of the transmitter config bank
`timescale 1ns/100ps
module txsc_monitor (
  input wire logic                MCLK,
  input wire logic                RST_N,
  input wire logic                SLEEP,
  input wire txsc_pkg::txsc_req_s REG_REQ,
  input wire logic [7:0]          REG_RDATA,
  input wire txsc_pkg::txsc_cal_s CAL_RESULT,
  input wire logic                OOK_MODE,
  input wire logic                TX_SYMBOL,
  input wire logic [2:0]          TABLE_SEL,
  input wire logic [1:0]          LO_BUFFER_CURRENT,
  input wire logic                PUMP_CAL_STAGE_EN,
  input wire logic [3:0]          PUMP_CURRENT,
  input wire logic                RIPPLE_EXPIRE,
  input wire logic                CHIP_READY_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Host writes the bank must take; sleep and a cal update win over them
  sequence s_wr22; REG_REQ.wr && REG_REQ.addr == 6'h22 && !SLEEP; endsequence
  sequence s_wr23; REG_REQ.wr && REG_REQ.addr == 6'h23 && !SLEEP && !CAL_RESULT.valid; endsequence
  property p_ook_zero; OOK_MODE && !TX_SYMBOL |=> TABLE_SEL == 3'h0; endproperty
  a_ook_zero: assert property (p_ook_zero) else $error("zero symbol off entry zero");
  property p_lobuf; s_wr22 |=> LO_BUFFER_CURRENT == $past(REG_REQ.wdata[5:4]); endproperty
  a_lobuf: assert property (p_lobuf) else $error("buffer current not written");
  property p_stage; s_wr23 ##0 REG_REQ.wdata[5:4] == 2'h0 |=> !PUMP_CAL_STAGE_EN; endproperty
  a_stage: assert property (p_stage) else $error("stage not skipped");
  property p_result; s_wr23 |=> PUMP_CURRENT == $past(REG_REQ.wdata[3:0]); endproperty
  a_result: assert property (p_result) else $error("override not taken");
  property p_cal; CAL_RESULT.valid && !SLEEP |=> PUMP_CURRENT == $past(CAL_RESULT.value); endproperty
  a_cal: assert property (p_cal) else $error("cal result not taken");
  property p_sleep; SLEEP && !CAL_RESULT.valid |=> LO_BUFFER_CURRENT == 2'h1 && PUMP_CURRENT == 4'h9; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not restore");
  property p_rsvd; REG_REQ.rd && REG_REQ.addr == 6'h22 |=> REG_RDATA[7:6] == 2'h0 && !REG_RDATA[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read one");
  property p_unmapped; REG_REQ.rd && !(REG_REQ.addr inside {6'h18, 6'h22, 6'h23}) |=> REG_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Ready may only drop on the edge after an expiry
  property p_ready; $fell(CHIP_READY_N) |-> $past(RIPPLE_EXPIRE); endproperty
  a_ready: assert property (p_ready) else $error("ready without expiry");
endmodule
bind txsc_top txsc_monitor txsc_monitor_i (.MCLK(MCLK), .RST_N(RST_N), .SLEEP(SLEEP), .REG_REQ(REG_REQ),
  .REG_RDATA(REG_RDATA), .CAL_RESULT(CAL_RESULT), .OOK_MODE(OOK_MODE), .TX_SYMBOL(TX_SYMBOL),
  .TABLE_SEL(TABLE_SEL), .LO_BUFFER_CURRENT(LO_BUFFER_CURRENT), .PUMP_CAL_STAGE_EN(PUMP_CAL_STAGE_EN),
  .PUMP_CURRENT(PUMP_CURRENT), .RIPPLE_EXPIRE(RIPPLE_EXPIRE), .CHIP_READY_N(CHIP_READY_N));

// *** dv/txsc_host.sv ***
// Host model: single-byte requests on the serial register port
`timescale 1ns/100ps
module txsc_host (
  input  wire logic          MCLK,
  input  wire logic [7:0]    REG_RDATA,
  output txsc_pkg::txsc_req_s REG_REQ
);
  initial REG_REQ = '0;
  // Strobe held to the taking edge; idle cycle after so no double drive
  task wr(input logic [5:0] a, input logic [7:0] d);
    REG_REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge MCLK) #2;
    REG_REQ = '0;
    @(posedge MCLK) #2;
  endtask
  // Read data is valid from the taking edge itself, sampled 2 ns after it
  task rd(input logic [5:0] a, output logic [7:0] d);
    REG_REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge MCLK) #2;
    REG_REQ = '0;
    d = REG_RDATA;
    @(posedge MCLK) #2;
  endtask
endmodule

// *** dv/tb_top.sv ***
// Testbench: register-port sequences against the transmitter config bank
`timescale 1ns/100ps
module tb_top;
  logic                mclk = 1'b0, rst_n = 1'b0, sleep = 1'b0, ook = 1'b0, sym = 1'b0, xosc = 1'b0, rip = 1'b0;
  txsc_pkg::txsc_req_s req;
  txsc_pkg::txsc_cal_s cal = '0;
  logic [7:0]          rdata;
  logic [2:0]          tsel;
  logic [1:0]          lobuf, ccfg;
  logic [3:0]          pcur;
  logic                stage_en, rdy_n;
  int                  n_errors = 0, n_tests = 0;
  int                  cnt[4] = '{1, 16, 64, 256};
  always #12.5 mclk = ~mclk;
  txsc_top txsc_top_i (.MCLK(mclk), .RST_N(rst_n), .SLEEP(sleep), .REG_REQ(req), .REG_RDATA(rdata),
    .CAL_RESULT(cal), .OOK_MODE(ook), .TX_SYMBOL(sym), .TABLE_SEL(tsel), .LO_BUFFER_CURRENT(lobuf),
    .CAL_CONFIG(ccfg), .PUMP_CAL_STAGE_EN(stage_en), .PUMP_CURRENT(pcur), .XOSC_STABLE(xosc),
    .RIPPLE_EXPIRE(rip), .CHIP_READY_N(rdy_n));
  txsc_host txsc_host_i (.MCLK(mclk), .REG_RDATA(rdata), .REG_REQ(req));
  // Inputs always move 2 ns after the edge
  task tick; @(posedge mclk) #2; endtask
  task chk(input bit ok);
    n_tests++;
    if (!ok) begin n_errors++; $display("CHECK FAILED %0t mismatch", $time); end
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    txsc_host_i.rd(a, d);
    chk(d === e);
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well past the longest timer run
  initial begin repeat (5000) @(posedge mclk); n_errors++; test_done; end
  initial begin
    repeat (4) @(posedge mclk);
    #2 rst_n = 1'b1;
    chk(stage_en === 1'b1 && ccfg === 2'h2 && pcur === 4'h9 && lobuf === 2'h1 && tsel === 3'h0);
    rdc(6'h18, 8'h08);
    rdc(6'h22, 8'h10);
    rdc(6'h23, 8'hA9);
    txsc_host_i.wr(6'h22, 8'hFF);
    rdc(6'h22, 8'h37);
    chk(tsel === 3'h7 && lobuf === 2'h3);
    // Zero symbols must leave the index unused
    ook = 1'b1; tick; tick; chk(tsel === 3'h0);
    sym = 1'b1; tick; tick; chk(tsel === 3'h7);
    txsc_host_i.wr(6'h23, 8'h4E);
    chk(stage_en === 1'b0 && ccfg === 2'h1 && pcur === 4'hE);
    cal.valid = 1'b1; cal.value = 4'h3; tick; cal.valid = 1'b0; tick;
    rdc(6'h23, 8'h43);
    txsc_host_i.wr(6'h24, 8'hFF);
    rdc(6'h24, 8'h00);
    txsc_host_i.wr(6'h18, 8'hFF);
    rdc(6'h18, 8'h0C);
    sleep = 1'b1; tick; tick; sleep = 1'b0; tick;
    rdc(6'h18, 8'h0C);
    rdc(6'h22, 8'h10);
    rdc(6'h23, 8'hA9);
    // Every timeout code, ready must hold off until the last expiry
    for (int c = 0; c < 4; c++) begin
      txsc_host_i.wr(6'h18, 8'(c << 2));
      xosc = 1'b1; tick; tick;
      for (int i = 0; i < cnt[c]; i++) begin
        chk(rdy_n === 1'b1);
        rip = 1'b1; tick; rip = 1'b0; tick;
      end
      chk(rdy_n === 1'b0);
      xosc = 1'b0; tick; tick;
    end
    // Mid-run reset must bring the retained timeout select back to its default
    rst_n = 1'b0;
    tick;
    rst_n = 1'b1;
    rdc(6'h18, 8'h08);
    test_done;
  end
endmodule
